/* fcs_pkg.sv */
// Constants, types and carriers shared by the flash command sequencer
// ****************************************************************
// ****************************************************************
package fcs_pkg;
	// Bus and array geometry
	localparam int          ADDR_W      = 9;       // Byte address width
	localparam int          DATA_W      = 16;      // Bus data width
	localparam int          WORDS       = 224;     // Words in user area
	localparam logic [3:0]  BLOCK_A     = 4'hD;    // Excluded block index
	localparam logic [3:0]  ERALL_LAST  = 4'hC;    // Last block of erase-all
	localparam logic [3:0]  BLK_TOP     = 4'hF;    // Word offset of block top
	// Command codes (low byte)
	localparam logic [7:0]  CMD_ARRAY   = 8'hFF;
	localparam logic [7:0]  CMD_STATUS  = 8'h70;
	localparam logic [7:0]  CMD_CLEAR   = 8'h50;
	localparam logic [7:0]  CMD_PROG    = 8'h40;
	localparam logic [7:0]  CMD_ERASE   = 8'h20;
	localparam logic [7:0]  CMD_ERALL   = 8'hA7;
	localparam logic [7:0]  CMD_LOCK    = 8'h77;
	localparam logic [7:0]  CMD_LSTAT   = 8'h71;
	localparam logic [7:0]  CMD_CONFIRM = 8'hD0;
	// Status byte layout
	localparam int          ST_READY_BIT = 7;
	localparam int          ST_ERASE_BIT = 5;
	localparam int          ST_PROG_BIT  = 4;
	// Reset values
	localparam logic        READY_RST   = 1'b1;
	localparam logic        ERR_RST     = 1'b0;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [13:0] LOCK_RST    = 14'h3FFF;  // All unlocked
	// Timing
	localparam int          CLK_MHZ      = 10;      // Core clock rate
	localparam int          PROG_TIME_US = 20;      // Word program time
	localparam int          ERASE_TIME_US = 100;    // Per-block erase time
	localparam int          LOCK_TIME_US = 20;      // Lock bit program time
	localparam int          LSTAT_TIME_US = 1;      // Lock bit read time
	localparam logic [9:0]  PROG_CYC  = 10'(PROG_TIME_US * CLK_MHZ);
	localparam logic [9:0]  ERASE_CYC = 10'(ERASE_TIME_US * CLK_MHZ);
	localparam logic [9:0]  LOCK_CYC  = 10'(LOCK_TIME_US * CLK_MHZ);
	localparam logic [9:0]  LSTAT_CYC = 10'(LSTAT_TIME_US * CLK_MHZ);

	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_PROG  = 3'b001,
		S_ERASE = 3'b010,
		S_ERALL = 3'b011,
		S_LOCK  = 3'b100,
		S_LSTAT = 3'b101
	} fcs_state_t;

	// Read modes
	typedef enum logic [0:0] {
		RM_ARRAY  = 1'b0,
		RM_STATUS = 1'b1
	} fcs_rmode_t;

	// One bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} fcs_bus_req_t;
endpackage : fcs_pkg

/* fcs_sequencer.sv */
// Flash command sequencer: decode, auto operations, status and lock logic
//
// Our own choices: the register addresses and strobed register access.
module fcs_sequencer (
	input  wire                        core_clk,
	input  wire                        nrst,
	input  wire fcs_pkg::fcs_bus_req_t bus_req,
	input  wire                        cpu_rewrite_enable,
	input  wire                        lock_protect_disable,
	input  wire                        ram_exec_rewrite_mode,
	output logic [15:0]                rdata,
	output logic                       seq_ready_flag,
	output logic                       program_error_flag,
	output logic                       erase_error_flag,
	output logic                       lock_status_flag
);
	import fcs_pkg::*;

	// ****************************************************************
	// Storage and state
	// ****************************************************************
	logic [15:0]  mem [0:WORDS-1];   // User area array
	logic [13:0]  lock_bits;         // Per-block lock, 0 = locked
	fcs_state_t   state;             // Sequencer state
	fcs_rmode_t   rd_mode;           // Read answer mode
	logic [9:0]   cnt;               // Operation timer
	logic         pend_valid;        // First cycle captured
	logic [7:0]   pend_code;         // First-cycle command
	logic [8:0]   pend_addr;         // First-cycle address
	logic [8:0]   op_addr;           // Target of running operation
	logic [15:0]  op_word;           // Word being programmed
	logic [3:0]   erall_blk;         // Erase-all block pointer

	// ****************************************************************
	// Address and command decode
	// ****************************************************************
	logic [3:0]   req_blk;           // Block of request
	logic [7:0]   req_widx;          // Word index of request
	logic [7:0]   code;              // Low byte of write data
	logic         in_area;           // Even address inside user area
	logic         blk_top;           // Highest even address of block
	logic         any_err;           // Either error flag set
	logic         cmd_wr;            // Accepted command write
	logic         first_wr;          // First bus cycle
	logic         second_wr;         // Second bus cycle
	logic         refusable;         // Command refused on errors
	logic         start_prog;
	logic         start_erase;
	logic         start_erall;
	logic         start_lock;
	logic         start_lstat;
	logic         seq_err;           // Bad second cycle
	logic         go_array;          // Enter array read
	logic         go_status;         // Enter status read
	logic         clr_stat;          // Clear error flags
	logic         done;              // Timer expired
	logic         op_locked;         // Target block protected
	logic [15:0]  old_word;          // Current word at program target
	logic [7:0]   status_byte;       // Status byte image

	assign req_blk   = bus_req.addr[8:5];
	assign req_widx  = bus_req.addr[8:1];
	assign code      = bus_req.wdata[7:0];
	assign in_area   = !bus_req.addr[0] && (req_blk <= BLOCK_A);
	assign blk_top   = (bus_req.addr[4:1] == BLK_TOP);
	assign any_err   = program_error_flag || erase_error_flag;
	assign cmd_wr    = bus_req.wr && in_area && cpu_rewrite_enable && (state == S_IDLE);
	assign first_wr  = cmd_wr && !pend_valid;
	assign second_wr = cmd_wr && pend_valid;
	assign refusable = (code == CMD_PROG) || (code == CMD_ERASE) ||
	                   (code == CMD_ERALL) || (code == CMD_LOCK);
	assign done      = (state != S_IDLE) && (cnt == 10'h000);
	assign old_word  = mem[op_addr[8:1]];
	assign op_locked = !lock_bits[op_addr[8:5]] && !lock_protect_disable;
	assign status_byte = {seq_ready_flag, 1'b0, erase_error_flag, program_error_flag, 4'h0};

	// First- and second-cycle outcomes
	always_comb begin
		start_prog  = 1'b0;
		start_erase = 1'b0;
		start_erall = 1'b0;
		start_lock  = 1'b0;
		start_lstat = 1'b0;
		seq_err     = 1'b0;
		go_array    = first_wr && (code == CMD_ARRAY);
		go_status   = first_wr && (code == CMD_STATUS);
		clr_stat    = first_wr && (code == CMD_CLEAR);
		if (second_wr) begin
			case (pend_code)
				CMD_PROG: begin
					// Same address in both cycles starts it
					start_prog = (bus_req.addr == pend_addr);
				end
				CMD_ERASE, CMD_ERALL, CMD_LOCK: begin
					if (code == CMD_CONFIRM) begin
						start_erase = (pend_code == CMD_ERASE) && blk_top;
						start_erall = (pend_code == CMD_ERALL);
						start_lock  = (pend_code == CMD_LOCK) && blk_top &&
						              (bus_req.addr == pend_addr);
					end else if (code == CMD_ARRAY) begin
						go_array = 1'b1;
					end else begin
						seq_err = 1'b1;
					end
				end
				CMD_LSTAT: begin
					start_lstat = (code == CMD_CONFIRM) && blk_top;
					go_array    = (code == CMD_ARRAY);
				end
				default: begin
					go_array = 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// Two-cycle command capture
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pend_valid <= 1'b0;
			pend_code  <= 8'h00;
			pend_addr  <= 9'h000;
		end else if (second_wr) begin
			// Any second cycle ends the pair
			pend_valid <= 1'b0;
		end else if (first_wr) begin
			// Program, erase, erase-all and lock refused while an error flag stands
			pend_valid <= (refusable && !any_err) || (code == CMD_LSTAT);
			pend_code  <= code;
			pend_addr  <= bus_req.addr;
		end
	end

	// ****************************************************************
	// Read mode
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rd_mode <= RM_ARRAY;
		end else if (go_array || start_lstat) begin
			rd_mode <= RM_ARRAY;
		end else if (go_status) begin
			rd_mode <= RM_STATUS;
		end else if (ram_exec_rewrite_mode &&
		             (start_prog || start_erase || start_erall || start_lock)) begin
			rd_mode <= RM_STATUS;
		end
	end

	// ****************************************************************
	// Sequencer state and timer
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state     <= S_IDLE;
			cnt       <= 10'h000;
			op_addr   <= 9'h000;
			op_word   <= 16'h0000;
			erall_blk <= 4'h0;
		end else begin
			case (state)
				S_IDLE: begin
					op_addr <= bus_req.addr;
					op_word <= bus_req.wdata;
					erall_blk <= 4'h0;
					if (start_prog) begin
						state <= S_PROG;
						cnt   <= PROG_CYC - 10'h001;
					end else if (start_erase) begin
						state <= S_ERASE;
						cnt   <= ERASE_CYC - 10'h001;
					end else if (start_erall) begin
						state <= S_ERALL;
						cnt   <= ERASE_CYC - 10'h001;
					end else if (start_lock) begin
						state <= S_LOCK;
						cnt   <= LOCK_CYC - 10'h001;
					end else if (start_lstat) begin
						state <= S_LSTAT;
						cnt   <= LSTAT_CYC - 10'h001;
					end
				end
				S_ERALL: begin
					// Blocks 0 to 12 in turn, block A never
					if (cnt != 10'h000) begin
						cnt <= cnt - 10'h001;
					end else if (erall_blk == ERALL_LAST) begin
						state <= S_IDLE;
					end else begin
						erall_blk <= erall_blk + 4'h1;
						cnt       <= ERASE_CYC - 10'h001;
					end
				end
				S_PROG, S_ERASE, S_LOCK, S_LSTAT: begin
					if (cnt != 10'h000) begin
						cnt <= cnt - 10'h001;
					end else begin
						state <= S_IDLE;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Ready flag
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			seq_ready_flag <= READY_RST;
		end else if (start_prog || start_erase || start_erall || start_lock || start_lstat) begin
			seq_ready_flag <= 1'b0;
		end else if (done && ((state != S_ERALL) || (erall_blk == ERALL_LAST))) begin
			seq_ready_flag <= 1'b1;
		end
	end

	// ****************************************************************
	// Error flags: a set beats a clear in the same cycle
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			program_error_flag <= ERR_RST;
			erase_error_flag   <= ERR_RST;
		end else begin
			if (clr_stat) begin
				program_error_flag <= 1'b0;
				erase_error_flag   <= 1'b0;
			end
			if (seq_err) begin
				program_error_flag <= 1'b1;
				erase_error_flag   <= 1'b1;
			end
			// Locked target or a bit that would go 0 to 1
			if (done && (state == S_PROG) &&
			    (op_locked || ((old_word & op_word) != op_word))) begin
				program_error_flag <= 1'b1;
			end
			if (done && (state == S_ERASE) && op_locked) begin
				erase_error_flag <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Lock bits and lock status
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lock_bits        <= LOCK_RST;
			lock_status_flag <= 1'b1;
		end else if (done) begin
			case (state)
				S_LOCK: lock_bits[op_addr[8:5]] <= 1'b0;
				S_LSTAT: lock_status_flag <= lock_bits[op_addr[8:5]];
				S_ERASE: begin
					if (!op_locked) begin
						lock_bits[op_addr[8:5]] <= 1'b1;
					end
				end
				S_ERALL: begin
					if (lock_bits[erall_blk] || lock_protect_disable) begin
						lock_bits[erall_blk] <= 1'b1;
					end
				end
				default: begin
					lock_status_flag <= lock_status_flag;
				end
			endcase
		end
	end

	// ****************************************************************
	// Array contents
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < WORDS; i++) begin
				mem[i] <= ERASED_WORD;
			end
		end else if (done) begin
			if ((state == S_PROG) && !op_locked && ((old_word & op_word) == op_word)) begin
				mem[op_addr[8:1]] <= op_word;
			end else if ((state == S_ERASE) && !op_locked) begin
				for (int j = 0; j < 16; j++) begin
					mem[{op_addr[8:5], 4'(j)}] <= ERASED_WORD;
				end
			end else if ((state == S_ERALL) &&
			             (lock_bits[erall_blk] || lock_protect_disable)) begin
				for (int j = 0; j < 16; j++) begin
					mem[{erall_blk, 4'(j)}] <= ERASED_WORD;
				end
			end
		end
	end

	// ****************************************************************
	// Read data, valid only in the cycle after the strobe
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 16'h0000;
		end else if (bus_req.rd && in_area) begin
			if (rd_mode == RM_STATUS) begin
				rdata <= {8'h00, status_byte};
			end else begin
				rdata <= mem[req_widx];
			end
		end else begin
			rdata <= 16'h0000;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	localparam int A_PROG_MAX = 201;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_status_read;
		bus_req.rd && in_area && (rd_mode == RM_STATUS) |=>
			(rdata == {8'h00, $past(status_byte)});
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	property p_array_cmd;
		first_wr && (code == CMD_ARRAY) |=> (rd_mode == RM_ARRAY);
	endproperty
	a_array_cmd: assert property (p_array_cmd) else $error("array mode not set");

	property p_clear;
		clr_stat |=> !program_error_flag && !erase_error_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("clear status failed");

	property p_prog_time;
		start_prog |=> !seq_ready_flag ##[1:A_PROG_MAX] seq_ready_flag;
	endproperty
	a_prog_time: assert property (p_prog_time) else $error("program ready timing");

	property p_busy_not_ready;
		(state != S_IDLE) |-> !seq_ready_flag;
	endproperty
	a_busy_not_ready: assert property (p_busy_not_ready) else $error("ready while busy");

	property p_ew0_status;
		ram_exec_rewrite_mode && (start_prog || start_erase) |=> (rd_mode == RM_STATUS);
	endproperty
	a_ew0_status: assert property (p_ew0_status) else $error("no status mode");

	property p_refuse;
		first_wr && any_err && refusable |=> !pend_valid;
	endproperty
	a_refuse: assert property (p_refuse) else $error("command not refused");

	property p_seq_err;
		seq_err |=> program_error_flag && erase_error_flag;
	endproperty
	a_seq_err: assert property (p_seq_err) else $error("sequence error missed");

	property p_erall_range;
		(state == S_ERALL) |-> (erall_blk <= ERALL_LAST);
	endproperty
	a_erall_range: assert property (p_erall_range) else $error("block A erased");

	c_prog:  cover property (start_prog ##1 (state == S_PROG) [*3]);
	c_erall: cover property ((state == S_ERALL) && (erall_blk == ERALL_LAST) && done);
	c_seq:   cover property (seq_err);
	c_lstat: cover property (start_lstat ##[1:20] $rose(seq_ready_flag));
endmodule : fcs_sequencer

/* fcs_cpu.sv */
// CPU-side bus master model driving the sequencer's command port
module fcs_cpu (
	input  wire logic             core_clk,
	input  wire logic [15:0]      rdata,
	output fcs_pkg::fcs_bus_req_t bus_req,
	output logic                  cpu_rewrite_enable,
	output logic                  lock_protect_disable,
	output logic                  ram_exec_rewrite_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	import fcs_pkg::*;

	// ****************************************
	// Idle bus and control levels at time zero
	// ****************************************
	initial begin
		bus_req = '0;
		cpu_rewrite_enable = 1'b0;
		lock_protect_disable = 1'b0;
		ram_exec_rewrite_mode = 1'b0;
	end

	// Control levels, changed only between operations
	task automatic set_mode(input logic ren, input logic lpd, input logic ram);
		@(posedge core_clk);
		cpu_rewrite_enable <= ren;
		lock_protect_disable <= lpd;
		ram_exec_rewrite_mode <= ram;
	endtask : set_mode

	// One-cycle 16-bit write; data turned over once released
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a & 9'h1FE, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
		bus_req.wdata <= ~d;
	endtask : wr

	// One-cycle 16-bit read; data taken in the following cycle
	task automatic rd(input logic [8:0] a, output logic [15:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a & 9'h1FE, wdata: bus_req.wdata, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		@(negedge core_clk);
		d = rdata;
	endtask : rd
endmodule : fcs_cpu

/* tb_top.sv */
// Self-checking bench for the flash command sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import fcs_pkg::*;

	// ****************************************
	// Signals and instances
	// ****************************************
	logic          core_clk;
	logic          nrst;
	fcs_bus_req_t  bus_req;
	logic [15:0]   rdata;
	logic          cpu_rewrite_enable;
	logic          lock_protect_disable;
	logic          ram_exec_rewrite_mode;
	logic          seq_ready_flag;
	logic          program_error_flag;
	logic          erase_error_flag;
	logic          lock_status_flag;
	logic [15:0]   seed = 16'h44AA;      // Random source state
	logic [8:0]    t2 = 9'h05E;          // Top word of block 2
	int            n_fail;
	int            checks_done;

	fcs_sequencer i_fcs_sequencer (
		.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
		.cpu_rewrite_enable(cpu_rewrite_enable),
		.lock_protect_disable(lock_protect_disable),
		.ram_exec_rewrite_mode(ram_exec_rewrite_mode), .rdata(rdata),
		.seq_ready_flag(seq_ready_flag), .program_error_flag(program_error_flag),
		.erase_error_flag(erase_error_flag), .lock_status_flag(lock_status_flag)
	);

	fcs_cpu i_fcs_cpu (
		.core_clk(core_clk), .rdata(rdata), .bus_req(bus_req),
		.cpu_rewrite_enable(cpu_rewrite_enable),
		.lock_protect_disable(lock_protect_disable),
		.ram_exec_rewrite_mode(ram_exec_rewrite_mode)
	);

	// ****************************************
	// Reference model of array, locks and flags
	// ****************************************
	int  mem[int];                        // Programmed words only
	bit  lk[14] = '{default: 1'b1};       // Lock bits, 1 unlocked
	bit  pe, ee, sm;                      // Errors and status mode
	bit  ls = 1'b1;                       // Last lock status
	int  pend = -1;                       // Pending first cycle
	int  pa, dur;                         // First address, busy span

	// Erase one block and unlock it
	function automatic void er(int b);
		for (int i = b * 16; i < b * 16 + 16; i++) mem.delete(i);
		lk[b] = 1'b1;
	endfunction : er

	// Accepted write as the sequencer should see it
	function automatic void m_wr(int a, int d);
		int c, w, b, old;
		bit top, lkd;
		c = d & 'hFF;
		w = a / 2;
		b = a / 32;
		top = (w % 16) == 15;
		lkd = !lock_protect_disable && !lk[b];
		old = mem.exists(w) ? mem[w] : 'hFFFF;
		dur = 0;
		if (!cpu_rewrite_enable) return;
		if (pend < 0) begin
			case (c)
				CMD_ARRAY: sm = 1'b0;
				CMD_STATUS: sm = 1'b1;
				CMD_CLEAR: begin pe = 1'b0; ee = 1'b0; end
				CMD_LSTAT: begin pend = c; sm = 1'b0; end
				CMD_PROG, CMD_ERASE, CMD_ERALL, CMD_LOCK: if (!pe && !ee) pend = c;
				default: ;
			endcase
			pa = a;
			return;
		end
		if (pend != CMD_PROG && pend != CMD_LSTAT && c != CMD_CONFIRM) begin
			if (c == CMD_ARRAY) sm = 1'b0;
			else begin pe = 1'b1; ee = 1'b1; end
		end else case (pend)
			CMD_PROG: if (a == pa) begin
				dur = PROG_CYC;
				if (lkd || (d & ~old & 'hFFFF) != 0) pe = 1'b1;
				else mem[w] = d;
			end
			CMD_ERASE: if (top) begin
				dur = ERASE_CYC;
				if (lkd) ee = 1'b1;
				else er(b);
			end
			CMD_ERALL: begin
				dur = 13 * ERASE_CYC;
				for (int i = 0; i < 13; i++) if (lock_protect_disable || lk[i]) er(i);
			end
			CMD_LOCK: if (top && a == pa) begin dur = LOCK_CYC; lk[b] = 1'b0; end
			default: if (c == CMD_ARRAY) sm = 1'b0;
			else if (top && c == CMD_CONFIRM) begin dur = LSTAT_CYC; ls = lk[b]; end
		endcase
		if (dur > 0 && ram_exec_rewrite_mode && pend != CMD_LSTAT) sm = 1'b1;
		pend = -1;
	endfunction : m_wr

	// Expected read data
	function automatic logic [15:0] m_rd(int a);
		if (a / 32 > 13) return 16'h0000;
		if (sm) return {8'h00, 1'b1, 1'b0, ee, pe, 4'h0};
		return mem.exists(a / 2) ? 16'(mem[a / 2]) : 16'hFFFF;
	endfunction : m_rd

	// ****************************************
	// Checking and bus helpers
	// ****************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	task automatic cmd(input logic [8:0] a, input logic [15:0] d);
		i_fcs_cpu.wr(a, d);
		m_wr(int'(a), int'(d));
	endtask : cmd

	task automatic rdchk(input logic [8:0] a);
		logic [15:0] v;
		i_fcs_cpu.rd(a, v);
		chk(v, m_rd(int'(a)));
	endtask : rdchk

	task automatic flags();
		chk({12'h000, seq_ready_flag, program_error_flag, erase_error_flag,
			lock_status_flag}, {12'h000, 1'b1, pe, ee, ls});
	endtask : flags

	// Busy span after a second cycle, then flags
	task automatic run();
		int n;
		n = 0;
		@(negedge core_clk);
		chk(16'(seq_ready_flag), 16'(dur == 0));
		while (seq_ready_flag !== 1'b1 && n < 20000) begin
			@(negedge core_clk);
			n++;
		end
		chk(16'(n), 16'(dur));
		flags();
	endtask : run

	// ****************************************
	// Clock, watchdog and main sequence
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		wrap_up();
	end

	initial begin
		nrst = 1'b0;
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		flags();
		rdchk(9'h000);
		rdchk(9'h1C0);
		i_fcs_cpu.set_mode(1'b1, 1'b0, 1'b1);
		// Random words, noisy upper command byte, status after start
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			cmd(9'(2 * i), 16'hAB40);
			cmd(9'(2 * i), seed & 16'h7FFF);
			run();
			rdchk(9'(2 * i));
			cmd(9'h000, 16'h00FF);
			rdchk(9'(2 * i));
		end
		// Zero to one rewrite fails, then commands refused until cleared
		cmd(9'h000, 16'h0040);
		cmd(9'h000, 16'hFFFF);
		run();
		cmd(9'h000, 16'h0070);
		rdchk(9'h010);
		cmd(9'h010, 16'h0040);
		cmd(9'h010, 16'h1234);
		run();
		cmd(9'h000, 16'h0050);
		rdchk(9'h010);
		// Word in block 2, then lock it and read its lock
		cmd(9'h040, 16'h0040);
		cmd(9'h040, 16'h5A5A);
		run();
		cmd(t2, 16'h0077);
		cmd(t2, 16'h00D0);
		run();
		cmd(9'h000, 16'h0071);
		cmd(t2, 16'h00D0);
		run();
		// Locked block erase fails on each of three tries
		for (int k = 0; k < 3; k++) begin
			cmd(9'h000, 16'h0050);
			cmd(9'h000, 16'h0020);
			cmd(t2, 16'h00D0);
			run();
		end
		// Bad second byte sets both errors; array code aborts
		cmd(9'h000, 16'h0050);
		cmd(9'h000, 16'h0020);
		cmd(9'h01E, 16'h0055);
		run();
		cmd(9'h000, 16'h0050);
		cmd(9'h000, 16'h00A7);
		cmd(9'h000, 16'h00FF);
		run();
		rdchk(9'h002);
		// Erase-all keeps the locked block and the excluded block
		cmd(9'h1A0, 16'h0040);
		cmd(9'h1A0, 16'hC3C3);
		run();
		cmd(9'h000, 16'h00A7);
		cmd(9'h000, 16'h00D0);
		run();
		rdchk(9'h000);
		cmd(9'h000, 16'h0071);
		cmd(t2, 16'h00D0);
		run();
		rdchk(9'h000);
		rdchk(9'h040);
		rdchk(9'h1A0);
		// Lock override erases block 2 and unlocks it
		i_fcs_cpu.set_mode(1'b1, 1'b1, 1'b0);
		cmd(9'h000, 16'h0020);
		cmd(t2, 16'h00D0);
		run();
		rdchk(9'h040);
		cmd(9'h000, 16'h0071);
		cmd(t2, 16'h00D0);
		run();
		// Lock status read dropped by array code; erase off block top dropped
		cmd(9'h000, 16'h0071);
		cmd(t2, 16'h00FF);
		run();
		cmd(9'h000, 16'h0020);
		cmd(9'h040, 16'h00D0);
		run();
		rdchk(9'h1A0);
		// Rewrite disabled last, no stop or clock change follows
		i_fcs_cpu.set_mode(1'b0, 1'b0, 1'b0);
		cmd(9'h000, 16'h0040);
		cmd(9'h000, 16'h0000);
		run();
		rdchk(9'h000);
		wrap_up();
	end
endmodule : tb_top
